// ### meob_pkg.sv
// constants and types for the m4 extension overhead bit framer
// Contract
// - power status in frames two and three
// - all power normal sends 11
// - battery bad, primary good sends 10
// - primary bad, battery good sends 01
// - both bad sends dying gasp 00
// - power status unused sends ones in SN3
// - test mode indicator in frame four
// - one normal, zero test, unused one
// - local customer maintenance means test mode
// - cold start only flag in frame five
// - cold start only one, else zero
// - received activation request drives s/t activation
// - s/t activity indicator in frame seven
// - activity one on INFO 1 or 3
// - activity unused sends one in SN3
package meob_pkg;
  // ----------------------------------------
  // multiframe positions (basic frame index 0..7)
  // ----------------------------------------
  localparam logic [2:0] MEOB_FRM_PS1 = 3'h1;
  localparam logic [2:0] MEOB_FRM_PS2 = 3'h2;
  localparam logic [2:0] MEOB_FRM_NTM = 3'h3;
  localparam logic [2:0] MEOB_FRM_CSO = 3'h4;
  localparam logic [2:0] MEOB_FRM_ACT7 = 3'h6;
  localparam logic [2:0] MEOB_FRM_LAST = 3'h7;
  localparam int MEOB_NFRM = 32'h0000_0008;
  // unused functions and idle positions send one
  localparam logic MEOB_BIT_UNUSED = 1'h1;
  // ----------------------------------------
  // power status codes
  // ----------------------------------------
  localparam logic [1:0] MEOB_PS_ALL_NORMAL = 2'h3;
  localparam logic [1:0] MEOB_PS_SEC_OUT = 2'h2;
  localparam logic [1:0] MEOB_PS_PRI_OUT = 2'h1;
  localparam logic [1:0] MEOB_PS_DYING_GASP = 2'h0;
  // ----------------------------------------
  // receive capture states
  // ----------------------------------------
  typedef enum logic [0:0] {
    MEOB_RX_WAIT = 1'b0,
    MEOB_RX_SYNC = 1'b1
  } meob_rx_state_t;
endpackage

// ### meob_rx_capture.sv
// receive side capture of the activation request bit
`timescale 1ns/1ns
`default_nettype none
module meob_rx_capture (
  input wire logic clk, // 25 mhz clock
  input wire logic sys_rst, // async reset, active high
  input wire logic rx_m4_valid, // one cycle pulse, m4 bit present
  input wire logic [2:0] rx_frame_idx, // basic frame index of that bit
  input wire logic rx_m4_bit, // received m4 bit
  output logic st_activate, // latest activation request
  output logic rx_update // pulse, multiframe values refreshed
);
  typedef struct packed {
    meob_pkg::meob_rx_state_t st;
    logic pend;
    logic act;
    logic upd;
  } meob_rx_t;
  meob_rx_t r;
  meob_rx_t next_r;

  always_comb begin
    next_r = r;
    next_r.upd = 1'b0;
    if (rx_m4_valid) begin
      if (rx_frame_idx == meob_pkg::MEOB_FRM_ACT7) begin
        next_r.pend = rx_m4_bit;
        next_r.st = meob_pkg::MEOB_RX_SYNC;
      end
      if (rx_frame_idx == meob_pkg::MEOB_FRM_LAST) begin
        case (r.st)
          meob_pkg::MEOB_RX_SYNC: begin
            next_r.act = r.pend;
            next_r.upd = 1'b1;
            next_r.st = meob_pkg::MEOB_RX_WAIT;
          end
          default: next_r.st = meob_pkg::MEOB_RX_WAIT;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{
        st: meob_pkg::MEOB_RX_WAIT,
        pend: meob_pkg::MEOB_BIT_UNUSED,
        act: meob_pkg::MEOB_BIT_UNUSED,
        upd: 1'h0
      };
    end else begin
      r <= next_r;
    end
  end

  assign st_activate = r.act;
  assign rx_update = r.upd;
endmodule
`default_nettype wire

// ### meob_framer.sv
// nt1 side m4 extension overhead bit inserter and extractor
`timescale 1ns/1ns
`default_nettype none
module meob_framer (
  input wire logic clk, // 25 mhz clock
  input wire logic sys_rst, // async reset, active high
  input wire logic tx_m4_req, // pulse, m4 bit needed for tx frame
  input wire logic [2:0] tx_frame_idx, // basic frame index being sent
  input wire logic tx_sn3, // sending SN3
  output logic tx_m4_bit, // registered m4 bit to insert
  output logic tx_m4_own, // registered, bit is an extension bit
  input wire logic ps_enable, // power status function used
  input wire logic primary_ok, // primary power normal
  input wire logic battery_ok, // back-up battery normal
  input wire logic ntm_enable, // test mode function used
  input wire logic maint_d, // local maintenance on d channel
  input wire logic maint_b1, // local maintenance on b1
  input wire logic maint_b2, // local maintenance on b2
  input wire logic cso_capable, // transceiver is cold start only
  input wire logic sai_enable, // s/t activity function used
  input wire logic st_info13, // INFO 1 or INFO 3 seen at s/t
  input wire logic rx_m4_valid, // pulse, received m4 bit present
  input wire logic [2:0] rx_frame_idx, // received basic frame index
  input wire logic rx_m4_bit, // received m4 bit
  output logic st_activate, // registered s/t activation request
  output logic rx_update // pulse, received values refreshed
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic bit_out;
    logic own;
  } meob_tx_t;
  meob_tx_t r;
  meob_tx_t next_r;
  logic [1:0] ps_code;
  logic test_mode;
  logic ntm_bit;
  logic cso_bit;
  logic sai_bit;
  logic [meob_pkg::MEOB_NFRM-1:0] tab_bit;
  logic [meob_pkg::MEOB_NFRM-1:0] tab_own;

  // ----------------------------------------
  // decoders
  // ----------------------------------------
  // power status pair from the two supplies
  function automatic logic [1:0] meob_ps_encode(
    input logic pri,
    input logic bat
  );
    logic [1:0] code;
    code = meob_pkg::MEOB_PS_DYING_GASP;
    if (pri && bat) begin
      code = meob_pkg::MEOB_PS_ALL_NORMAL;
    end else if (pri) begin
      code = meob_pkg::MEOB_PS_SEC_OUT;
    end else if (bat) begin
      code = meob_pkg::MEOB_PS_PRI_OUT;
    end
    return code;
  endfunction

  // optional indicator, an unused function sends one
  function automatic logic meob_opt_bit(
    input logic used,
    input logic value
  );
    logic b;
    b = meob_pkg::MEOB_BIT_UNUSED;
    if (used) begin
      b = value;
    end
    return b;
  endfunction

  // frames that carry an extension bit toward the line
  function automatic logic meob_is_ext(
    input logic [2:0] idx
  );
    logic hit;
    case (idx)
      meob_pkg::MEOB_FRM_PS1: begin
        hit = 1'h1;
      end
      meob_pkg::MEOB_FRM_PS2: begin
        hit = 1'h1;
      end
      meob_pkg::MEOB_FRM_NTM: begin
        hit = 1'h1;
      end
      meob_pkg::MEOB_FRM_CSO: begin
        hit = 1'h1;
      end
      meob_pkg::MEOB_FRM_ACT7: begin
        hit = 1'h1;
      end
      default: begin
        hit = 1'h0;
      end
    endcase
    return hit;
  endfunction

  // bit carried at one frame position
  function automatic logic meob_pos_bit(
    input logic [2:0] idx,
    input logic [1:0] ps,
    input logic ntm,
    input logic cso,
    input logic sai
  );
    logic b;
    case (idx)
      meob_pkg::MEOB_FRM_PS1: begin
        b = ps[1];
      end
      meob_pkg::MEOB_FRM_PS2: begin
        b = ps[0];
      end
      meob_pkg::MEOB_FRM_NTM: begin
        b = ntm;
      end
      meob_pkg::MEOB_FRM_CSO: begin
        b = cso;
      end
      meob_pkg::MEOB_FRM_ACT7: begin
        b = sai;
      end
      default: begin
        b = meob_pkg::MEOB_BIT_UNUSED;
      end
    endcase
    return b;
  endfunction

  // ----------------------------------------
  // indicator sources
  // ----------------------------------------
  assign ps_code = ps_enable ? meob_ps_encode(primary_ok, battery_ok)
    : meob_pkg::MEOB_PS_ALL_NORMAL;
  assign test_mode = maint_d | maint_b1 | maint_b2;
  assign ntm_bit = meob_opt_bit(ntm_enable, ~test_mode);
  assign cso_bit = cso_capable;
  assign sai_bit = meob_opt_bit(sai_enable, st_info13);

  // ----------------------------------------
  // position table
  // ----------------------------------------
  // one entry per basic frame of the multiframe
  for (genvar g = 0; g < meob_pkg::MEOB_NFRM; g++) begin : g_pos
    assign tab_own[g] = meob_is_ext(3'(g));
    assign tab_bit[g] = meob_pos_bit(3'(g), ps_code, ntm_bit, cso_bit, sai_bit);
  end

  // ----------------------------------------
  // transmit insertion
  // ----------------------------------------
  always_comb begin
    next_r = r;
    if (tx_m4_req) begin
      next_r.own = tab_own[tx_frame_idx];
      next_r.bit_out = tab_bit[tx_frame_idx];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{bit_out: meob_pkg::MEOB_BIT_UNUSED, own: 1'h0};
    end else begin
      r <= next_r;
    end
  end

  assign tx_m4_bit = r.bit_out;
  assign tx_m4_own = r.own;

  // ----------------------------------------
  // receive extraction
  // ----------------------------------------
  meob_rx_capture u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .rx_m4_valid(rx_m4_valid),
    .rx_frame_idx(rx_frame_idx),
    .rx_m4_bit(rx_m4_bit),
    .st_activate(st_activate),
    .rx_update(rx_update)
  );
endmodule
`default_nettype wire

// ### meob_lt_model.sv
// far end line transceiver model sending m4 bits
`timescale 1ns/1ns
`default_nettype none
module meob_lt_model (
  input wire logic clk, // framer clock
  input wire logic go, // send multiframes while high
  input wire logic act_req, // activation request to send
  input wire logic drop, // lose the frame seven strobe
  output logic valid, // m4 bit strobe
  output logic [2:0] idx, // basic frame index
  output logic m4 // m4 bit
);
  logic [2:0] cnt = 3'h0;
  initial valid = 1'h0;
  initial idx = 3'h0;
  initial m4 = 1'h0;
  always @(posedge clk) begin
    valid <= go && !(drop && cnt == 3'h6);
    idx <= cnt;
    m4 <= (go && cnt == 3'h6) ? act_req : ~m4;
    if (go) begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ### meob_framer_props.sv
// assertions on the framer ports
`timescale 1ns/1ns
`default_nettype none
module meob_framer_props (
  input wire logic clk, // framer clock
  input wire logic sys_rst, // async reset, active high
  input wire logic tx_m4_req, // m4 bit wanted
  input wire logic [2:0] tx_frame_idx, // tx basic frame index
  input wire logic tx_m4_bit, // inserted m4 bit
  input wire logic tx_m4_own, // bit is an extension bit
  input wire logic ps_enable, // power status used
  input wire logic primary_ok, // primary power normal
  input wire logic battery_ok, // battery normal
  input wire logic ntm_enable, // test mode used
  input wire logic maint_d, // d channel maintenance
  input wire logic maint_b1, // b1 maintenance
  input wire logic maint_b2, // b2 maintenance
  input wire logic cso_capable, // cold start only
  input wire logic sai_enable, // activity used
  input wire logic st_info13, // s/t activity seen
  input wire logic rx_m4_valid, // received m4 strobe
  input wire logic [2:0] rx_frame_idx, // rx basic frame index
  input wire logic rx_m4_bit, // received m4 bit
  input wire logic st_activate, // activation request
  input wire logic rx_update // refresh pulse
);
  logic seen6;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // last request bit seen at frame seven
  always_ff @(posedge clk) begin
    if (rx_m4_valid && rx_frame_idx == 3'h6) begin
      seen6 <= rx_m4_bit;
    end
  end
  cso_bit_a: assert property (tx_m4_req && tx_frame_idx == 3'h4 |=>
    tx_m4_bit == $past(cso_capable)) else $error("bad cold start bit");
  act_value_a: assert property (rx_update |-> st_activate == seen6)
    else $error("bad request value");
  upd_single_a: assert property (rx_update |=> !rx_update)
    else $error("long update");
  ps_first_a: assert property (tx_m4_req && tx_frame_idx == 3'h1 |=>
    tx_m4_bit == $past(!ps_enable || primary_ok)) else $error("bad ps1");
  ps_second_a: assert property (tx_m4_req && tx_frame_idx == 3'h2 |=>
    tx_m4_bit == $past(!ps_enable || battery_ok)) else $error("bad ps2");
  test_mode_a: assert property (tx_m4_req && tx_frame_idx == 3'h3 |=>
    tx_m4_bit == $past(!ntm_enable || !(maint_d || maint_b1 || maint_b2)))
    else $error("bad test bit");
  st_act_a: assert property (tx_m4_req && tx_frame_idx == 3'h6 |=>
    tx_m4_bit == $past(!sai_enable || st_info13)) else $error("bad activity");
  own_pos_a: assert property (tx_m4_req |=> tx_m4_own ==
    $past(tx_frame_idx inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6})) else $error("bad own");
  tx_hold_a: assert property (!tx_m4_req |=> $stable(tx_m4_bit) && $stable(tx_m4_own))
    else $error("tx bit moved");
  upd_cause_a: assert property (rx_update |-> $past(rx_m4_valid && rx_frame_idx == 3'h7))
    else $error("stray update");
  act_hold_a: assert property (!rx_update |-> $stable(st_activate))
    else $error("request moved");
  cover property (tx_m4_req && tx_frame_idx == 3'h1 && !primary_ok && !battery_ok);
  cover property (tx_m4_req && tx_frame_idx == 3'h3 && maint_b2 && ntm_enable);
  cover property (rx_update && !st_activate);
  cover property (tx_m4_req && tx_frame_idx == 3'h6 && sai_enable && st_info13);
endmodule
bind meob_framer meob_framer_props props_u (
  .clk(clk),
  .sys_rst(sys_rst),
  .tx_m4_req(tx_m4_req),
  .tx_frame_idx(tx_frame_idx),
  .tx_m4_bit(tx_m4_bit),
  .tx_m4_own(tx_m4_own),
  .ps_enable(ps_enable),
  .primary_ok(primary_ok),
  .battery_ok(battery_ok),
  .ntm_enable(ntm_enable),
  .maint_d(maint_d),
  .maint_b1(maint_b1),
  .maint_b2(maint_b2),
  .cso_capable(cso_capable),
  .sai_enable(sai_enable),
  .st_info13(st_info13),
  .rx_m4_valid(rx_m4_valid),
  .rx_frame_idx(rx_frame_idx),
  .rx_m4_bit(rx_m4_bit),
  .st_activate(st_activate),
  .rx_update(rx_update)
);
`default_nettype wire

// ### meob_framer_tb_top.sv
// testbench for the m4 extension overhead bit framer
`timescale 1ns/1ns
`default_nettype none
module meob_framer_tb_top;
  logic clk = 1'h0, sys_rst = 1'h1, req = 1'h0, pse = 1'h1, pri = 1'h1, bat = 1'h1;
  logic ntme = 1'h1, cso = 1'h0, sae = 1'h1, inf = 1'h0, go = 1'h0, lreq = 1'h1;
  logic drop = 1'h0;
  logic [2:0] idx = 3'h0, md = 3'h0, ridx;
  logic rv, rb, txb, own, act, upd;
  int error_cnt = 0, n_tests = 0;
  always #20 clk = ~clk;
  meob_lt_model lt_u (.clk(clk), .go(go), .act_req(lreq), .drop(drop), .valid(rv),
    .idx(ridx), .m4(rb));
  meob_framer dut_u (.clk(clk), .sys_rst(sys_rst), .tx_m4_req(req), .tx_frame_idx(idx),
    .tx_sn3(1'h1), .tx_m4_bit(txb), .tx_m4_own(own), .ps_enable(pse), .primary_ok(pri),
    .battery_ok(bat), .ntm_enable(ntme), .maint_d(md[0]), .maint_b1(md[1]),
    .maint_b2(md[2]), .cso_capable(cso), .sai_enable(sae), .st_info13(inf),
    .rx_m4_valid(rv), .rx_frame_idx(ridx), .rx_m4_bit(rb), .st_activate(act),
    .rx_update(upd));
  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic txq(input logic [2:0] i, input logic e);
    req = 1'h1;
    idx = i;
    @(negedge clk);
    chk(txb, e);
    chk(own, i inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6});
  endtask
  task automatic t_ps();
    pse = 1'h1;
    for (int k = 0; k < 4; k++) begin
      {pri, bat} = k[1:0];
      txq(3'h1, k[1]);
      txq(3'h2, k[0]);
    end
    {pri, bat} = 2'h0;
    pse = 1'h0;
    txq(3'h1, 1'h1);
    txq(3'h2, 1'h1);
    pse = 1'h1;
  endtask
  task automatic t_ntm();
    ntme = 1'h1;
    for (int k = 0; k < 4; k++) begin
      md = (k == 0) ? 3'h0 : 3'h1 << (k - 1);
      txq(3'h3, k == 0);
    end
    ntme = 1'h0;
    txq(3'h3, 1'h1);
    ntme = 1'h1;
  endtask
  task automatic t_cso_sai();
    for (int k = 0; k < 8; k++) begin
      {cso, sae, inf} = 3'(k);
      txq(3'h4, k[2]);
      txq(3'h6, !k[1] || k[0]);
    end
  endtask
  task automatic t_nonext();
    {pri, bat} = 2'h0;
    md = 3'h1;
    {cso, sae, inf} = 3'h2;
    txq(3'h0, 1'h1);
    txq(3'h5, 1'h1);
    txq(3'h7, 1'h1);
    req = 1'h0;
  endtask
  task automatic t_rx_drop();
    drop = 1'h1;
    go = 1'h1;
    repeat (16) begin
      @(negedge clk);
      chk(upd, 1'h0);
    end
    go = 1'h0;
    drop = 1'h0;
    chk(act, 1'h0);
  endtask
  task automatic t_reset();
    pse = 1'h1;
    {pri, bat} = 2'h0;
    txq(3'h1, 1'h0);
    req = 1'h0;
    sys_rst = 1'h1;
    repeat (2) @(negedge clk);
    chk(txb, 1'h1);
    chk(own, 1'h0);
    chk(act, 1'h1);
    chk(upd, 1'h0);
    sys_rst = 1'h0;
    {pri, bat} = 2'h2;
    txq(3'h1, 1'h1);
    txq(3'h2, 1'h0);
    req = 1'h0;
  endtask
  task automatic t_rx();
    int n;
    for (int r = 0; r < 3; r++) begin
      lreq = r[0];
      go = 1'h1;
      n = 0;
      while (upd !== 1'h1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      go = 1'h0;
      chk(upd, 1'h1);
      chk(act, r[0]);
      @(negedge clk);
      chk(upd, 1'h0);
      repeat (9) @(negedge clk);
      chk(act, r[0]);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 1'h0;
    t_ps();
    t_ntm();
    t_cso_sai();
    t_nonext();
    t_rx();
    t_rx_drop();
    t_reset();
    tally_and_finish();
  end
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
